//--- rtl/effective_address_generator.sv
/*
  Operand and branch effective address generation with byte read-modify-write
  sequencing for bit instructions.
  Assumes one clock, the register file supplied combinationally on ports,
  and a memory that answers a byte read with rd_valid.
*/
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [RULE_01] Set, clear, invert, store bit ops read byte, change bit, write back.
// [RULE_02] Write-only register reads as all ones; write-back may set other bits.
// [RULE_03] Register direct selects byte half, word half or 32-bit register.
// [RULE_04] Register indirect address is the pointer's lower 24 bits.
// [RULE_05] Displacement, 16-bit sign-extended or 24-bit, added to the pointer.
// [RULE_06] Post-increment uses pointer, then adds 1, 2 or 4 to full register.
// [RULE_07] Pre-decrement subtracts 1, 2 or 4 first, stores, uses result.
// [RULE_08] Software keeps pointers even for word or longword auto-steps.
// [RULE_09] 8-bit absolute fills upper address bits with ones.
// [RULE_10] 16-bit absolute sign-extends bit 15 into upper eight bits.
// [RULE_11] 24-bit absolute reaches the whole space unchanged.
// [RULE_12] Immediate operand comes from the instruction, 8, 16 or 32 bits.
// [RULE_13] Trap carries 2-bit vector; bit ops carry 3-bit bit number.
// [RULE_14] Bit ops use register direct, indirect or 8-bit absolute only.
// [RULE_15] PC-relative sign-extends 8 or 16-bit displacement, adds to PC.
// [RULE_16] PC base is the next instruction's first byte address.
// [RULE_17] Memory indirect reads longword at zero-extended 8-bit address.
// [RULE_18] Word, longword and branch addresses have bit zero forced low.
// [RULE_19] One-megabyte modes drop the upper four address bits.
// [RULE_20] Transfers exclude PC-relative, memory indirect; arithmetic direct, imm.
// [RULE_21] A 24-bit extension is a 32-bit value with top byte zero.
// [RULE_22] Sixteen-megabyte modes present all 24 address bits unchanged.
module effective_address_generator
  import ea_gen_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic                    start,
  input  wire ea_gen_pkg::request_type req,
  input  wire logic [23:0]             next_pc,
  input  wire logic                    mode_1mb,
  input  var  logic [31:0]             reg_file [8],
  input  wire logic                    carry_in,
  input  wire logic                    rd_valid,
  input  wire logic [31:0]             rd_data,
  input  wire logic                    rd_write_only,
  output var  ea_gen_pkg::result_type  result,
  output logic                         done,
  output logic                         ptr_we,
  output logic [2:0]                   ptr_sel,
  output logic [31:0]                  ptr_value,
  output logic                         mem_rd,
  output logic                         mem_wr,
  output logic                         mem_long,
  output logic [23:0]                  mem_addr,
  output logic [7:0]                   mem_wdata,
  output logic                         zero_flag
);
  import ea_gen_pkg::*;

  // Every check below lives in the one clock domain
  default clocking chk_clk @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  typedef enum logic [2:0] {
    st_idle,
    st_read,
    st_write,
    st_mind,
    st_done
  } state_type;

  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------
  wire logic [2:0]  ptr_idx  = req.reg_field[2:0];
  wire logic [31:0] ptr      = reg_file[ptr_idx];
  wire logic [31:0] ext24    = {EXT24_TOP, req.ext[23:0]}; // RULE_21
  wire logic [31:0] disp16   = {{16{req.ext[15]}}, req.ext[15:0]};
  wire logic [31:0] step     = (req.size == sz_long) ? STEP_LONG :
                               (req.size == sz_word) ? STEP_WORD : STEP_BYTE;
  wire logic [31:0] ptr_inc  = ptr + step; // RULE_06
  wire logic [31:0] ptr_dec  = ptr - step; // RULE_07
  wire logic [31:0] sum16    = ptr + disp16; // RULE_05
  wire logic [31:0] sum24    = ptr + ext24; // RULE_05
  wire logic [23:0] pc_d8    = {{16{req.ext[7]}}, req.ext[7:0]};
  wire logic [23:0] pc_d16   = {{8{req.ext[15]}}, req.ext[15:0]};
  wire logic [23:0] pc_tgt8  = next_pc + pc_d8; // RULE_15 RULE_16
  wire logic [23:0] pc_tgt16 = next_pc + pc_d16; // RULE_15 RULE_16
  wire logic [23:0] abs8     = {ABS8_UPPER, req.ext[7:0]}; // RULE_09
  wire logic [23:0] abs16    = {{8{req.ext[15]}}, req.ext[15:0]}; // RULE_10
  wire logic [23:0] mind     = {MIND_UPPER, req.ext[7:0]}; // RULE_17

  logic [23:0] raw_addr;
  always_comb begin
    case (req.mode)
      am_reg_indirect: raw_addr = ptr[23:0]; // RULE_04
      am_disp16:       raw_addr = sum16[23:0];
      am_disp24:       raw_addr = sum24[23:0];
      am_post_inc:     raw_addr = ptr[23:0]; // RULE_06
      am_pre_dec:      raw_addr = ptr_dec[23:0]; // RULE_07
      am_abs8:         raw_addr = abs8;
      am_abs16:        raw_addr = abs16;
      am_abs24:        raw_addr = ext24[23:0]; // RULE_11
      am_pc_rel8:      raw_addr = pc_tgt8;
      am_pc_rel16:     raw_addr = pc_tgt16;
      am_mem_indirect: raw_addr = mind;
      default:         raw_addr = 24'h000000;
    endcase
  end

  // Branch targets and wide operands never land on an odd byte
  wire logic        force_even = (req.size != sz_byte) ||
                                 (req.iclass == cl_branch) ||
                                 (req.mode == am_mem_indirect);
  wire logic [23:0] even_addr  = force_even ? {raw_addr[23:1], 1'b0}
                                            : raw_addr; // RULE_18
  wire logic [23:0] ea_addr    = mode_1mb ?
                                 {NARROW_DROP, even_addr[19:0]} // RULE_19
                                 : even_addr; // RULE_22

  // ----------------------------------------------------------------
  // Mode legality per instruction class
  // ----------------------------------------------------------------
  wire logic is_pcrel = (req.mode == am_pc_rel8) ||
                        (req.mode == am_pc_rel16);
  wire logic is_rd    = (req.mode == am_reg_direct);
  wire logic is_imm   = (req.mode == am_immediate);
  logic legal;
  always_comb begin
    case (req.iclass)
      cl_transfer: legal = !is_pcrel && req.mode != am_mem_indirect; // RULE_20
      cl_arith:    legal = is_rd || is_imm; // RULE_20
      cl_bit:      legal = is_rd || req.mode == am_reg_indirect ||
                           req.mode == am_abs8; // RULE_14
      cl_branch:   legal = is_pcrel;
      cl_jump:     legal = req.mode == am_mem_indirect ||
                           req.mode == am_reg_indirect ||
                           req.mode == am_abs24;
      cl_trap:     legal = 1'b1;
      default:     legal = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register direct and immediate operand selection
  // ----------------------------------------------------------------
  wire logic [31:0] rd_reg  = reg_file[req.reg_field[2:0]];
  wire logic [7:0]  rd_b    = req.reg_field[3] ? rd_reg[7:0] : rd_reg[15:8];
  wire logic [15:0] rd_w    = req.reg_field[3] ? rd_reg[31:16] : rd_reg[15:0];
  wire logic [31:0] rd_op   = (req.size == sz_byte) ? {24'h000000, rd_b} :
                              (req.size == sz_word) ? {16'h0000, rd_w} :
                              rd_reg; // RULE_03
  wire logic [31:0] imm_op  = (req.size == sz_byte) ?
                              {24'h000000, req.ext[7:0]} :
                              (req.size == sz_word) ? {16'h0000, req.ext[15:0]} :
                              req.ext; // RULE_12

  // ----------------------------------------------------------------
  // Bit manipulation
  // ----------------------------------------------------------------
  wire logic [2:0]  bit_no   = req.bit_from_reg ? rd_reg[2:0]
                                                : req.bit_imm; // RULE_13
  wire logic        mem_bit  = (req.iclass == cl_bit) && !is_rd;
  wire logic        rmw      = mem_bit && req.bitop != bo_test &&
                               req.bitop != bo_none; // RULE_01
  wire logic [7:0]  byte_in  = rd_write_only ? WO_READ : rd_data[7:0]; // RULE_02
  logic [7:0] byte_out;
  always_comb begin
    byte_out = byte_in;
    case (req.bitop)
      bo_set:       byte_out[bit_no] = 1'b1;
      bo_clear:     byte_out[bit_no] = 1'b0;
      bo_invert:    byte_out[bit_no] = ~byte_in[bit_no];
      bo_store:     byte_out[bit_no] = carry_in;
      bo_store_inv: byte_out[bit_no] = ~carry_in;
      default:      byte_out = byte_in;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  state_type  state_q;
  state_type  state_d;
  wire logic  auto_step = (req.mode == am_post_inc) ||
                          (req.mode == am_pre_dec);
  wire logic  is_mind   = (req.iclass == cl_jump) &&
                          (req.mode == am_mem_indirect);

  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: begin
        if (start && is_mind) begin
          state_d = st_mind;
        end else if (start && mem_bit) begin
          state_d = st_read;
        end else if (start) begin
          state_d = st_done;
        end
      end
      st_read: begin
        if (rd_valid) begin
          state_d = rmw ? st_write : st_done;
        end
      end
      st_write: state_d = st_done;
      st_mind: begin
        if (rd_valid) begin
          state_d = st_done;
        end
      end
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // Register outputs; request must stay stable until done
  wire logic [23:0] mind_tgt  = mode_1mb ? {NARROW_DROP, rd_data[19:1], 1'b0}
                                         : {rd_data[23:1], 1'b0}; // RULE_17
  wire logic        entering  = (state_q == st_idle) && start;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      result    <= '0;
      done      <= 1'b0;
      ptr_we    <= 1'b0;
      ptr_sel   <= 3'h0;
      ptr_value <= 32'h0000_0000;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_long  <= 1'b0;
      mem_addr  <= 24'h000000;
      mem_wdata <= 8'h00;
      zero_flag <= 1'b0;
    end else begin
      done   <= (state_d == st_done) && (state_q != st_done);
      ptr_we <= entering && auto_step;
      mem_rd <= (state_d == st_read || state_d == st_mind) &&
                !(rd_valid && state_q != st_idle);
      mem_wr <= (state_q == st_read) && rd_valid && rmw; // RULE_01
      if (entering) begin
        ptr_sel         <= ptr_idx;
        ptr_value       <= (req.mode == am_post_inc) ? ptr_inc : ptr_dec;
        mem_addr        <= ea_addr;
        mem_long        <= is_mind;
        result.addr     <= ea_addr;
        result.legal    <= legal;
        result.is_reg   <= is_rd;
        result.operand  <= is_rd ? rd_op : imm_op;
        result.trap_vec <= req.trap_imm; // RULE_13
      end
      if (state_q == st_read && rd_valid) begin
        mem_wdata      <= byte_out; // RULE_01
        zero_flag      <= ~byte_in[bit_no];
        result.operand <= {24'h000000, byte_in};
      end
      if (state_q == st_mind && rd_valid) begin
        result.addr <= mind_tgt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence rmw_read_seq;
    state_q == st_read && rd_valid && rmw;
  endsequence

  // Touched bit worked out apart from byte_out, so a slip there shows
  wire logic want_bit = (req.bitop == bo_set) ||
                        (req.bitop == bo_invert && !byte_in[bit_no]) ||
                        (req.bitop == bo_store && carry_in) ||
                        (req.bitop == bo_store_inv && !carry_in);

  chk_rmw_write: assert property ( // RULE_01
    rmw_read_seq |=> mem_wr && mem_wdata[bit_no] == $past(want_bit))
    else $error("bit write-back missing");
  chk_rmw_keep: assert property ( // RULE_01
    rmw_read_seq |=> ((mem_wdata ^ $past(byte_in)) &
                      ~(8'h01 << bit_no)) == 8'h00)
    else $error("other bits changed on write-back");
  chk_rmw_single: assert property ( // RULE_01
    mem_wr |=> !mem_wr)
    else $error("write-back not a single pulse");
  chk_wo_read: assert property ( // RULE_02
    state_q == st_read && rd_valid && rd_write_only && req.bitop == bo_clear
    |=> (mem_wdata | (8'h01 << bit_no)) == 8'hff)
    else $error("write-only read not all ones");
  chk_post_inc: assert property ( // RULE_06
    entering && req.mode == am_post_inc
    |=> ptr_we && ptr_value == $past(ptr_inc) &&
        mem_addr[0] == $past(ea_addr[0]))
    else $error("post-increment wrong");
  chk_pre_dec: assert property ( // RULE_07
    entering && req.mode == am_pre_dec && !mode_1mb && req.size == sz_byte
    |=> result.addr == ptr_value[23:0])
    else $error("pre-decrement address wrong");
  chk_abs8_high: assert property ( // RULE_09
    entering && req.mode == am_abs8 && !mode_1mb
    |=> result.addr[23:8] == ABS8_UPPER)
    else $error("short absolute not high");
  chk_abs16_sign: assert property ( // RULE_10
    entering && req.mode == am_abs16 && !mode_1mb
    |=> result.addr[23:16] == {8{result.addr[15]}})
    else $error("short absolute not sign-extended");
  chk_wide_space: assert property ( // RULE_22
    entering && req.mode == am_abs24 && !mode_1mb
    |=> result.addr == $past(req.ext[23:0]))
    else $error("full absolute address altered");
  chk_even_addr: assert property ( // RULE_18
    entering && req.size != sz_byte |=> !result.addr[0])
    else $error("odd wide address");
  chk_branch_even: assert property ( // RULE_18
    entering && req.iclass == cl_branch |=> !result.addr[0])
    else $error("odd branch target");
  chk_narrow_space: assert property ( // RULE_19
    entering && mode_1mb |=> result.addr[23:20] == NARROW_DROP)
    else $error("upper bits kept in small space");
  chk_bit_modes: assert property ( // RULE_14
    entering && req.iclass == cl_bit && !is_rd &&
    req.mode != am_reg_indirect && req.mode != am_abs8
    |=> !result.legal)
    else $error("illegal bit mode accepted");
  chk_arith_modes: assert property ( // RULE_20
    entering && req.iclass == cl_arith && !is_rd && !is_imm
    |=> !result.legal)
    else $error("illegal arithmetic mode accepted");
  chk_trap_vec: assert property ( // RULE_13
    entering && req.iclass == cl_trap
    |=> result.trap_vec == $past(req.trap_imm))
    else $error("trap vector not passed on");
  chk_mind_read: assert property ( // RULE_17
    entering && is_mind
    |=> mem_rd && mem_long && mem_addr[23:8] == MIND_UPPER)
    else $error("indirect read not issued");
  chk_mind_done: assert property ( // RULE_17
    state_q == st_mind && rd_valid |=> done && !result.addr[0])
    else $error("indirect target wrong");

endmodule
`default_nettype wire

//--- rtl/ea_gen_pkg.sv
/*
  Shared types and constants for the effective address generator.
  Assumes a 32-bit register file and a 24-bit physical address space.
*/
package ea_gen_pkg;

  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned NARROW_W    = 20;
  localparam logic [7:0]  ABS8_FILL   = 8'hff;
  localparam logic [15:0] ABS8_UPPER  = 16'hffff;
  localparam logic [7:0]  EXT24_TOP   = 8'h00;
  localparam logic [15:0] MIND_UPPER  = 16'h0000;
  localparam logic [3:0]  NARROW_DROP = 4'h0;
  localparam logic [31:0] STEP_BYTE   = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD   = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG   = 32'h0000_0004;
  localparam logic [7:0]  WO_READ     = 8'hff;

  typedef enum logic [3:0] {
    am_reg_direct,
    am_reg_indirect,
    am_disp16,
    am_disp24,
    am_post_inc,
    am_pre_dec,
    am_abs8,
    am_abs16,
    am_abs24,
    am_immediate,
    am_pc_rel8,
    am_pc_rel16,
    am_mem_indirect
  } mode_type;

  typedef enum logic [1:0] {
    sz_byte,
    sz_word,
    sz_long
  } size_type;

  typedef enum logic [2:0] {
    cl_transfer,
    cl_arith,
    cl_bit,
    cl_branch,
    cl_jump,
    cl_trap
  } class_type;

  typedef enum logic [2:0] {
    bo_none,
    bo_set,
    bo_clear,
    bo_invert,
    bo_store,
    bo_store_inv,
    bo_test
  } bitop_type;

  typedef struct packed {
    class_type   iclass;
    mode_type    mode;
    size_type    size;
    bitop_type   bitop;
    logic        bit_from_reg;
    logic [3:0]  reg_field;
    logic [2:0]  bit_imm;
    logic [1:0]  trap_imm;
    logic [31:0] ext;
  } request_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              legal;
    logic              is_reg;
    logic [31:0]       operand;
    logic [1:0]        trap_vec;
  } result_type;

endpackage

//--- testbench/effective_address_generator_tb.sv
/*
  Self-checking bench for the effective address generator.
  Assumes the design package and module are compiled before this file.
*/
`timescale 1ns/10ps
`default_nettype none
module effective_address_generator_tb;
  import ea_gen_pkg::*;
  // ----------
  // Signals
  // ----------
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        start = 1'b0;
  request_type req = '0;
  logic [23:0] next_pc = 24'h001000;
  logic        mode_1mb = 1'b0;
  logic [31:0] reg_file [8] = '{default: 32'h0};
  logic        carry_in = 1'b0;
  logic        rd_valid = 1'b0;
  logic [31:0] rd_data = 32'h0;
  logic        rd_write_only = 1'b0;
  result_type  result;
  logic        done, ptr_we, mem_rd, mem_wr, mem_long, zero_flag;
  logic [2:0]  ptr_sel;
  logic [31:0] ptr_value, pv;
  logic [23:0] mem_addr, wa, ra;
  logic [7:0]  mem_wdata, wd;
  logic        wr_seen, we_seen, ml;
  int          fails = 0;
  int          n_checks = 0;

  always #10 mclk = ~mclk;

  effective_address_generator i_dut (.mclk(mclk), .rst_b(rst_b),
    .start(start), .req(req), .next_pc(next_pc), .mode_1mb(mode_1mb),
    .reg_file(reg_file), .carry_in(carry_in), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_write_only(rd_write_only), .result(result),
    .done(done), .ptr_we(ptr_we), .ptr_sel(ptr_sel),
    .ptr_value(ptr_value), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_long(mem_long), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .zero_flag(zero_flag));

  // ----------
  // Helpers
  // ----------
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic request_type mk(class_type c, mode_type m,
                                     size_type s, logic [3:0] rf,
                                     logic [31:0] x);
    mk = '0;
    mk.iclass = c;
    mk.mode = m;
    mk.size = s;
    mk.reg_field = rf;
    mk.ext = x;
  endfunction

  // One request; answers reads one cycle after mem_rd, logs writes
  task automatic go(input request_type r);
    logic nxt;
    @(posedge mclk);
    req <= r;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    wr_seen = 1'b0;
    we_seen = 1'b0;
    #1;
    for (int k = 0; k < 20; k++) begin
      if (mem_rd === 1'b1) begin
        ra = mem_addr;
        ml = mem_long;
      end
      if (mem_wr === 1'b1) begin
        wr_seen = 1'b1;
        wa = mem_addr;
        wd = mem_wdata;
      end
      if (ptr_we === 1'b1) begin
        we_seen = 1'b1;
        pv = ptr_value;
      end
      if (done === 1'b1)
        break;
      nxt = (mem_rd === 1'b1) && (rd_valid !== 1'b1);
      @(posedge mclk);
      rd_valid <= nxt;
      #1;
    end
    chk("done", done, 32'h1);
  endtask

  task automatic ea(input mode_type m, input size_type s,
                    input logic [3:0] rf, input logic [31:0] x,
                    input logic [23:0] e);
    go(mk(cl_transfer, m, s, rf, x));
    chk("addr", result.addr, e);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_ind;
    ea(am_reg_indirect, sz_byte, 4'h3, 32'h0, 24'h123457);
    ea(am_reg_indirect, sz_word, 4'h3, 32'h0, 24'h123456);
    ea(am_disp16, sz_byte, 4'h3, 32'h0000fff0, 24'h123447);
    ea(am_disp24, sz_byte, 4'h3, 32'h00100000, 24'h223457);
    ea(am_disp16, sz_long, 4'h3, 32'h00000002, 24'h123458);
  endtask

  // Pointers kept even for word and longword steps
  task automatic t_auto;
    logic [31:0] st;
    for (int i = 0; i < 3; i++) begin
      st = 32'h1 << i;
      ea(am_post_inc, size_type'(i), 4'h2, 32'h0, 24'hfffffe);
      chk("inc_we", we_seen, 32'h1);
      chk("inc_sel", ptr_sel, 32'h2);
      chk("inc_val", pv, 32'h00fffffe + st);
      ea(am_pre_dec, size_type'(i), 4'h5, 32'h0, 24'h000000 - st[23:0]);
      chk("dec_val", pv, 32'h01000000 - st);
    end
  endtask

  task automatic ab(input mode_type m, input logic [31:0] x,
                    input logic [23:0] e);
    @(posedge mclk);
    mode_1mb <= 1'b0;
    ea(m, sz_byte, 4'h0, x, e);
    @(posedge mclk);
    mode_1mb <= 1'b1;
    ea(m, sz_byte, 4'h0, x, {4'h0, e[19:0]});
    mode_1mb <= 1'b0;
  endtask

  task automatic rd(input size_type s, input logic [3:0] rf,
                    input logic [31:0] e);
    go(mk(cl_arith, am_reg_direct, s, rf, 32'h0));
    chk("reg_op", result.operand, e);
    chk("is_reg", result.is_reg, 32'h1);
  endtask

  task automatic br(input mode_type m, input logic [23:0] pc,
                    input logic [31:0] x, input logic [23:0] e);
    @(posedge mclk);
    next_pc <= pc;
    go(mk(cl_branch, m, sz_byte, 4'h0, x));
    chk("target", result.addr, e);
  endtask

  task automatic bt(input bitop_type op, input logic [2:0] b,
                    input logic [7:0] rv, input logic wo, input logic c,
                    input logic [7:0] ew);
    request_type r;
    r = mk(cl_bit, am_abs8, sz_byte, 4'h0, 32'h00000040);
    r.bitop = op;
    r.bit_imm = b;
    @(posedge mclk);
    rd_data <= {24'hffffff, rv};
    rd_write_only <= wo;
    carry_in <= c;
    go(r);
    chk("rd_addr", ra, 24'hffff40);
    chk("wr_seen", wr_seen, op != bo_test);
    if (op == bo_test)
      chk("zero", zero_flag, !rv[b]);
    else begin
      chk("wr_addr", wa, 24'hffff40);
      chk("wr_data", wd, ew);
    end
  endtask

  task automatic lg(input class_type c, input mode_type m, input logic e);
    go(mk(c, m, sz_byte, 4'h3, 32'h00000010));
    chk("legal", result.legal, e);
  endtask

  // Trap vectors, and a bit number taken from a register
  task automatic t_misc;
    request_type r;
    for (int v = 0; v < 4; v++) begin
      r = mk(cl_trap, am_immediate, sz_byte, 4'h0, 32'h0);
      r.trap_imm = 2'(v);
      go(r);
      chk("trap", result.trap_vec, v);
    end
    r = mk(cl_bit, am_abs8, sz_byte, 4'h6, 32'h00000040);
    r.bitop = bo_set;
    r.bit_from_reg = 1'b1;
    @(posedge mclk);
    rd_data <= 32'h00000001;
    rd_write_only <= 1'b0;
    go(r);
    chk("reg_bit", wd, 32'h81);
  endtask

  // ----------
  // Main
  // ----------
  initial begin
    reg_file[2] = 32'h00fffffe;
    reg_file[3] = 32'h5a123457;
    reg_file[5] = 32'h01000000;
    reg_file[6] = 32'h89abcdef;
    repeat (16) @(posedge mclk);
    chk("rst_done", done, 32'h0);
    rst_b <= 1'b1;
    t_ind();
    t_auto();
    ab(am_abs8, 32'h00000034, 24'hffff34);
    ab(am_abs16, 32'h00008123, 24'hff8123);
    ab(am_abs16, 32'h00007ffe, 24'h007ffe);
    ab(am_abs24, 32'h00abcdef, 24'habcdef);
    rd(sz_byte, 4'h6, 32'h000000cd);
    rd(sz_byte, 4'he, 32'h000000ef);
    rd(sz_word, 4'h6, 32'h0000cdef);
    rd(sz_word, 4'he, 32'h000089ab);
    rd(sz_long, 4'h6, 32'h89abcdef);
    go(mk(cl_arith, am_immediate, sz_long, 4'h0, 32'hdeadbeef));
    chk("imm", result.operand, 32'hdeadbeef);
    br(am_pc_rel8, 24'h001000, 32'h00000080, 24'h000f80);
    br(am_pc_rel8, 24'h001000, 32'h0000007f, 24'h00107e);
    br(am_pc_rel16, 24'h001000, 32'h00007fff, 24'h008ffe);
    br(am_pc_rel8, 24'h000010, 32'h00000080, 24'hffff90);
    @(posedge mclk);
    rd_data <= 32'hff123457;
    go(mk(cl_jump, am_mem_indirect, sz_long, 4'h0, 32'h000000f0));
    chk("mi_addr", ra, 24'h0000f0);
    chk("mi_long", ml, 32'h1);
    chk("mi_tgt", result.addr, 24'h123456);
    bt(bo_clear, 3'd0, 8'h3f, 1'b1, 1'b0, 8'hfe);
    bt(bo_set, 3'd7, 8'h01, 1'b0, 1'b0, 8'h81);
    bt(bo_invert, 3'd3, 8'hff, 1'b0, 1'b0, 8'hf7);
    bt(bo_store, 3'd5, 8'h00, 1'b0, 1'b1, 8'h20);
    bt(bo_store_inv, 3'd5, 8'hff, 1'b0, 1'b1, 8'hdf);
    bt(bo_test, 3'd2, 8'h04, 1'b0, 1'b0, 8'h00);
    bt(bo_test, 3'd2, 8'hfb, 1'b0, 1'b0, 8'h00);
    lg(cl_transfer, am_pc_rel8, 1'b0);
    lg(cl_transfer, am_mem_indirect, 1'b0);
    lg(cl_transfer, am_abs24, 1'b1);
    lg(cl_arith, am_reg_indirect, 1'b0);
    lg(cl_arith, am_reg_direct, 1'b1);
    lg(cl_bit, am_disp16, 1'b0);
    lg(cl_bit, am_reg_indirect, 1'b1);
    t_misc();
    give_verdict();
  end

  // Roughly thirty times the expected run length
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
